// File: testbench/bmsd_board_model.sv
// board model: select pin straps, toggling noise on the other pins and a uart character source
`timescale 1ns/1ps

module bmsd_board_model (
  input wire logic clock,
  input wire logic [7:0] pin0,
  input wire logic [7:0] pin1,
  input wire logic [7:0] pin2,
  input wire logic [2:0] code,
  output logic [255:0] gpio_level,
  output logic uart_rx_valid,
  output logic [7:0] uart_rx_data
);
  logic [255:0] noise_q;

  initial
  begin
    noise_q = {64{4'hA}};
    uart_rx_valid = 1'b0;
    uart_rx_data = 8'h00;
  end

  // unstrapped pins toggle every cycle so a wrong pin choice shows up
  always @(posedge clock)
    noise_q <= ~noise_q;

  always_comb
  begin
    gpio_level = noise_q;
    if (pin0 != 8'hFF)
      gpio_level[pin0] = code[0];
    if (pin1 != 8'hFF)
      gpio_level[pin1] = code[1];
    if (pin2 != 8'hFF)
      gpio_level[pin2] = code[2];
  end

  // one character, then the data lines show the inverse of it
  task send(input logic [7:0] c);
    uart_rx_valid <= 1'b1;
    uart_rx_data <= c;
    @(posedge clock);
    uart_rx_valid <= 1'b0;
    uart_rx_data <= ~c;
    @(posedge clock);
  endtask
endmodule

// File: testbench/bmsd_props.sv
// assertion checker for the boot mode select decoder
`timescale 1ns/1ps

module bmsd_props (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic usb_present,
  input wire logic flash_entry_programmed,
  input wire logic uart_rx_valid,
  input wire logic [7:0] uart_rx_data,
  input wire logic boot_done,
  input wire logic [2:0] boot_index,
  input wire logic [7:0] boot_entry,
  input wire logic [7:0] boot_mode,
  input wire logic usb_boot,
  input wire logic illegal_trap,
  input wire logic xtal_enable,
  input wire logic watchdog_enable,
  input wire logic autobaud_wait,
  input wire logic autobaud_locked,
  input wire logic [1:0] periph_instance,
  input wire logic [31:0] flash_entry_addr
);
  default clocking @(posedge clock);
  endclocking
  default disable iff (sys_rst);

  // only at the rise: strap inputs may move while an old result still stands
  sequence blank_flash_s;
    $rose(boot_done) && boot_entry == 8'h03 && !flash_entry_programmed;
  endsequence
  sequence lock_char_s;
    autobaud_wait && uart_rx_valid && (uart_rx_data == 8'h41 || uart_rx_data == 8'h61);
  endsequence

  usb_fallback_a: assert property (blank_flash_s ##0 usb_present |->
    usb_boot && boot_mode == 8'h09)
    else $error("blank flash did not fall back to usb");
  trap_fallback_a: assert property (blank_flash_s ##0 !usb_present |->
    illegal_trap && !usb_boot)
    else $error("blank flash without usb did not trap");
  fallback_scope_a: assert property (boot_done && boot_entry != 8'h03 |->
    !usb_boot && !illegal_trap)
    else $error("fallback raised for a non-default entry");
  autobaud_lock_a: assert property (lock_char_s |=> autobaud_locked)
    else $error("autobaud did not lock on the lock character");
  autobaud_mode_a: assert property (autobaud_wait |->
    boot_mode[4:0] == 5'h01 && !autobaud_locked)
    else $error("autobaud wait outside uart mode");
  can_xtal_a: assert property (boot_done && boot_mode[4:0] == 5'h02 |-> xtal_enable)
    else $error("can boot without crystal enable");
  first_instance_a: assert property (boot_done |-> periph_instance == 2'h0)
    else $error("peripheral instance not the first");
  flash_entry_a: assert property (boot_done && boot_mode == 8'h03 |->
    flash_entry_addr == 32'h00080000)
    else $error("default flash entry point wrong");
  wait_watchdog_a: assert property (boot_done |-> watchdog_enable == (boot_mode != 8'h24))
    else $error("watchdog enable does not match mode");
  latched_result_a: assert property (boot_done ##1 boot_done |->
    $stable(boot_index) && $stable(boot_entry))
    else $error("latched boot result changed");
endmodule

bind bmsd_boot_select bmsd_props u_props (.clock(clock), .sys_rst(sys_rst),
  .usb_present(usb_present), .flash_entry_programmed(flash_entry_programmed),
  .uart_rx_valid(uart_rx_valid), .uart_rx_data(uart_rx_data), .boot_done(boot_done),
  .boot_index(boot_index), .boot_entry(boot_entry), .boot_mode(boot_mode),
  .usb_boot(usb_boot), .illegal_trap(illegal_trap), .xtal_enable(xtal_enable),
  .watchdog_enable(watchdog_enable), .autobaud_wait(autobaud_wait),
  .autobaud_locked(autobaud_locked), .periph_instance(periph_instance),
  .flash_entry_addr(flash_entry_addr));

// File: testbench/tb_top.sv
// self-checking testbench for the boot mode select decoder
`timescale 1ns/1ps

module tb_top;
  logic clock, sys_rst, hsel, hwrite, hreadyout, hresp, usb_present, flash_entry_programmed;
  logic uart_rx_valid, boot_done, usb_boot, illegal_trap, xtal_enable, watchdog_enable;
  logic autobaud_wait, autobaud_locked;
  logic [31:0] haddr, hwdata, hrdata, flash_entry_addr, rd;
  logic [1:0] htrans, periph_instance;
  logic [2:0] hsize, boot_index, code;
  logic [7:0] uart_rx_data, boot_entry, boot_mode, pin0, pin1, pin2;
  logic [255:0] gpio_level;
  int err_count, checks;

  always #50 clock = ~clock;

  bmsd_boot_select u_dut (.clock(clock), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .gpio_level(gpio_level),
    .usb_present(usb_present), .flash_entry_programmed(flash_entry_programmed),
    .uart_rx_valid(uart_rx_valid), .uart_rx_data(uart_rx_data), .boot_done(boot_done),
    .boot_index(boot_index), .boot_entry(boot_entry), .boot_mode(boot_mode),
    .usb_boot(usb_boot), .illegal_trap(illegal_trap), .xtal_enable(xtal_enable),
    .watchdog_enable(watchdog_enable), .autobaud_wait(autobaud_wait),
    .autobaud_locked(autobaud_locked), .periph_instance(periph_instance),
    .flash_entry_addr(flash_entry_addr));

  bmsd_board_model u_board (.clock(clock), .pin0(pin0), .pin1(pin1), .pin2(pin2), .code(code),
    .gpio_level(gpio_level), .uart_rx_valid(uart_rx_valid), .uart_rx_data(uart_rx_data));

  task check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      err_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task end_of_test;
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // one single word transfer, entered and left right after a rising edge
  task ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    do @(posedge clock); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clock); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  task wait_done;
    int n;
    n = 0;
    while (boot_done !== 1'b1 && n < 20)
    begin
      @(posedge clock);
      n++;
    end
    check(32'(boot_done), 32'h1);
  endtask

  // rerun the decode and compare the latched index and table byte
  task boot(input logic dbg, input logic [2:0] idx, input logic [7:0] ent);
    ahb(1'b1, bmsd_pkg::OFS_CONTROL, {30'h0, 1'b1, dbg});
    @(posedge clock);
    wait_done();
    check(32'(boot_index), 32'(idx));
    check(32'(boot_entry), 32'(ent));
  endtask

  task test_default;
    for (int c = 0; c < 4; c++)
    begin
      code <= c[2:0];
      boot(1'b0, c[2:0], c[7:0]);
      check(32'(xtal_enable), 32'(c == 2));
    end
    check(32'(usb_boot), 32'h1);
    check(32'(boot_mode), 32'h09);
    usb_present <= 1'b0;
    boot(1'b0, 3'h3, 8'h03);
    check(32'(illegal_trap), 32'h1);
    check(32'(usb_boot), 32'h0);
    check(flash_entry_addr, bmsd_pkg::FLASH_ENTRY_0);
    check(32'(periph_instance), 32'(bmsd_pkg::FIRST_INSTANCE));
    code <= 3'h1;
    for (int i = 0; i < 2; i++)
    begin
      boot(1'b0, 3'h1, 8'h01);
      check(32'(autobaud_wait), 32'h1);
      u_board.send(8'h62);
      check(32'(autobaud_locked), 32'h0);
      u_board.send(i == 0 ? 8'h41 : 8'h61);
      check(32'(autobaud_locked), 32'h1);
    end
    $display("test default pins done");
  endtask

  task test_custom;
    logic [63:0] tbl;
    tbl = 64'h2B0B240307060504;
    usb_present <= 1'b1;
    flash_entry_programmed <= 1'b1;
    ahb(1'b1, bmsd_pkg::OFS_ZONE1_CFG, 32'h5A05FF0A);
    ahb(1'b1, bmsd_pkg::OFS_ZONE1_TBL_LO, tbl[31:0]);
    ahb(1'b1, bmsd_pkg::OFS_ZONE1_TBL_HI, tbl[63:32]);
    ahb(1'b0, bmsd_pkg::OFS_ZONE1_CFG, 32'h0);
    check(rd, 32'h5A05FF0A);
    pin0 <= 8'd10;
    pin1 <= 8'hFF;
    pin2 <= 8'd5;
    for (int c = 0; c < 8; c++)
    begin
      code <= c[2:0];
      boot(1'b0, c[2:0] & 3'h5, tbl[8 * (c & 5) +: 8]);
    end
    code <= 3'h0;
    repeat (3) @(posedge clock);
    check(32'(boot_index), 32'h5);
    $display("test custom pins done");
  endtask

  task test_zone2;
    ahb(1'b1, bmsd_pkg::OFS_ZONE2_CFG, 32'h5AFFFFFF);
    ahb(1'b1, bmsd_pkg::OFS_ZONE2_TBL_LO, 32'h000022E3);
    boot(1'b0, 3'h0, 8'hE3);
    check(32'(boot_mode), 32'h04);
    check(32'(watchdog_enable), 32'h1);
    ahb(1'b1, bmsd_pkg::OFS_ZONE2_CFG, 32'h5A24FF14);
    pin0 <= 8'd32;
    pin2 <= 8'hFF;
    code <= 3'h7;
    boot(1'b0, 3'h1, 8'h22);
    ahb(1'b1, bmsd_pkg::OFS_DEBUG_CFG, 32'h5AFFFFFF);
    ahb(1'b1, bmsd_pkg::OFS_DEBUG_TBL_LO, 32'h00000024);
    boot(1'b1, 3'h0, 8'h24);
    check(32'(watchdog_enable), 32'h0);
    ahb(1'b0, 8'h30, 32'h0);
    check(rd, 32'h0);
    check(32'(hresp), 32'h0);
    $display("test zone two and debug done");
  endtask

  initial
  begin
    clock = 1'b0;
    sys_rst = 1'b1;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    usb_present = 1'b1;
    flash_entry_programmed = 1'b0;
    code = 3'h0;
    pin0 = 8'd32;
    pin1 = 8'd24;
    pin2 = 8'hFF;
    err_count = 0;
    checks = 0;
    repeat (5) @(posedge clock);
    sys_rst <= 1'b0;
    wait_done();
    check(32'(boot_index), 32'h0);
    test_default();
    test_custom();
    test_zone2();
    end_of_test();
  end

  // about twenty decodes of under ten cycles each fit well inside this span
  initial
  begin
    #(100 * 20000);
    err_count++;
    end_of_test();
  end
endmodule

// File: verilog/bmsd_boot_select.sv
// boot mode select decoder with its register file on an ahb-lite slave
`timescale 1ns/1ps

module bmsd_boot_select #(
  parameter int NUM_GPIO = 256
) (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  input wire logic [NUM_GPIO-1:0] gpio_level,
  input wire logic usb_present,
  input wire logic flash_entry_programmed,
  input wire logic uart_rx_valid,
  input wire logic [7:0] uart_rx_data,
  output logic boot_done,
  output logic [2:0] boot_index,
  output logic [7:0] boot_entry,
  output logic [7:0] boot_mode,
  output logic usb_boot,
  output logic illegal_trap,
  output logic xtal_enable,
  output logic watchdog_enable,
  output logic autobaud_wait,
  output logic autobaud_locked,
  output logic [1:0] periph_instance,
  output logic [31:0] flash_entry_addr
);

  typedef struct packed {
    logic [31:0] zone1_pin_config_word;
    logic [31:0] zone2_pin_config_word;
    logic [31:0] debug_pin_config_copy;
    logic [31:0] zone1_table_low_word;
    logic [31:0] zone1_table_high_word;
    logic [31:0] zone2_table_low_word;
    logic [31:0] zone2_table_high_word;
    logic [31:0] debug_table_low_copy;
    logic [31:0] debug_table_high_copy;
    logic use_debug;
    logic wr_pend;
    logic [7:0] wr_addr;
    logic [31:0] rdata;
    bmsd_pkg::bmsd_state_t state;
    logic [1:0] src;
    logic key_ok;
    logic [7:0] select_pin_zero;
    logic [7:0] select_pin_one;
    logic [7:0] select_pin_two;
    logic [63:0] table_word;
    logic [2:0] index;
    logic [7:0] entry;
    logic [7:0] mode;
    logic done;
    logic usb;
    logic trap;
    logic xtal;
    logic wdog;
    logic ab_wait;
    logic ab_lock;
    logic [31:0] flash_addr;
  } bmsd_state_s_t;

  bmsd_state_s_t st_q;
  bmsd_state_s_t st_d;

  // true for gpio numbers that can never be a select pin
  function automatic logic pin_invalid(input logic [7:0] pin);
    pin_invalid = (pin == bmsd_pkg::BAD_PIN_A) || (pin == bmsd_pkg::BAD_PIN_B) ||
                  (pin == bmsd_pkg::BAD_PIN_C) || (pin == bmsd_pkg::BAD_PIN_D) ||
                  ((pin >= bmsd_pkg::BAD_RANGE_LO) && (pin <= bmsd_pkg::BAD_RANGE_HI));
  endfunction

  // field value after disable and invalid-pin handling
  function automatic logic [7:0] pin_fix(input logic [7:0] pin, input logic [7:0] dflt);
    if (pin == bmsd_pkg::PIN_DISABLED)
    begin
      pin_fix = bmsd_pkg::PIN_DISABLED;
    end
    else if (pin_invalid(pin))
    begin
      pin_fix = dflt;
    end
    else
    begin
      pin_fix = pin;
    end
  endfunction

  // sampled level of one select pin, zero when disabled or off the port
  function automatic logic pin_level(input logic [7:0] pin, input logic [NUM_GPIO-1:0] lv);
    if (pin == bmsd_pkg::PIN_DISABLED || 32'(pin) >= NUM_GPIO)
    begin
      pin_level = 1'b0;
    end
    else
    begin
      pin_level = lv[pin];
    end
  endfunction

  // entry value names a mode and an option that exist
  function automatic logic entry_supported(input logic [7:0] e);
    logic [2:0] opt;
    logic [7:0] base;
    opt = e[7:bmsd_pkg::OPT_LSB];
    base = {3'h0, e[bmsd_pkg::MODE_W-1:0]};
    case (base)
      bmsd_pkg::MODE_PARALLEL: entry_supported = (opt <= 3'h1);
      bmsd_pkg::MODE_UART: entry_supported = (opt <= 3'h4);
      bmsd_pkg::MODE_CAN: entry_supported = (opt <= 3'h2);
      bmsd_pkg::MODE_FLASH: entry_supported = (opt <= 3'h4);
      bmsd_pkg::MODE_WAIT: entry_supported = (opt <= 3'h1);
      bmsd_pkg::MODE_RAM: entry_supported = (opt == 3'h0);
      bmsd_pkg::MODE_SPI: entry_supported = (opt <= 3'h3);
      bmsd_pkg::MODE_I2C: entry_supported = (opt <= 3'h2);
      bmsd_pkg::MODE_MCAN: entry_supported = (opt <= 3'h2);
      bmsd_pkg::MODE_USB: entry_supported = (opt == 3'h0);
      bmsd_pkg::MODE_LFU: entry_supported = (opt <= 3'h1);
      default: entry_supported = 1'b0;
    endcase
  endfunction

  // flash entry point of a flash option
  function automatic logic [31:0] flash_addr_of(input logic [2:0] opt);
    case (opt)
      3'h0: flash_addr_of = bmsd_pkg::FLASH_ENTRY_0;
      3'h1: flash_addr_of = bmsd_pkg::FLASH_ENTRY_1;
      3'h2: flash_addr_of = bmsd_pkg::FLASH_ENTRY_2;
      3'h3: flash_addr_of = bmsd_pkg::FLASH_ENTRY_3;
      default: flash_addr_of = bmsd_pkg::FLASH_ENTRY_4;
    endcase
  endfunction

  logic addr_phase;
  logic [31:0] cfg_word;
  logic [63:0] tbl_word;
  logic [7:0] entry_sel;
  logic [7:0] mode_sel;
  logic [7:0] base_sel;
  logic [31:0] status_word;
  logic ab_char;

  always_comb
  begin
    st_d = st_q;
    addr_phase = hsel && htrans[1] && hready;
    cfg_word = st_q.zone1_pin_config_word;
    tbl_word = {st_q.zone1_table_high_word, st_q.zone1_table_low_word};
    entry_sel = st_q.table_word[8*st_q.index +: 8];
    mode_sel = entry_sel;
    base_sel = 8'h00;
    ab_char = 1'b0;
    status_word = {8'h00, st_q.mode, st_q.entry, 1'b0, st_q.index, st_q.src, st_q.key_ok,
                   st_q.done};

    // bus write data phase
    st_d.wr_pend = 1'b0;
    if (st_q.wr_pend)
    begin
      case (st_q.wr_addr)
        bmsd_pkg::OFS_ZONE1_CFG: st_d.zone1_pin_config_word = hwdata;
        bmsd_pkg::OFS_ZONE2_CFG: st_d.zone2_pin_config_word = hwdata;
        bmsd_pkg::OFS_DEBUG_CFG: st_d.debug_pin_config_copy = hwdata;
        bmsd_pkg::OFS_ZONE1_TBL_LO: st_d.zone1_table_low_word = hwdata;
        bmsd_pkg::OFS_ZONE1_TBL_HI: st_d.zone1_table_high_word = hwdata;
        bmsd_pkg::OFS_ZONE2_TBL_LO: st_d.zone2_table_low_word = hwdata;
        bmsd_pkg::OFS_ZONE2_TBL_HI: st_d.zone2_table_high_word = hwdata;
        bmsd_pkg::OFS_DEBUG_TBL_LO: st_d.debug_table_low_copy = hwdata;
        bmsd_pkg::OFS_DEBUG_TBL_HI: st_d.debug_table_high_copy = hwdata;
        bmsd_pkg::OFS_CONTROL:
        begin
          st_d.use_debug = hwdata[bmsd_pkg::CTRL_USE_DEBUG_BIT];
          // rerun is only honoured once a decode has finished
          if (hwdata[bmsd_pkg::CTRL_RERUN_BIT] && st_q.done)
          begin
            st_d.state = bmsd_pkg::ST_RESOLVE;
            st_d.done = 1'b0;
            st_d.ab_lock = 1'b0;
            st_d.ab_wait = 1'b0;
          end
        end
        default: st_d.wr_pend = 1'b0;
      endcase
    end

    // bus address phase; read data is prepared here so the answer has no wait state
    if (addr_phase)
    begin
      st_d.wr_pend = hwrite;
      st_d.wr_addr = haddr[7:0];
      case (haddr[7:0])
        bmsd_pkg::OFS_ZONE1_CFG: st_d.rdata = st_q.zone1_pin_config_word;
        bmsd_pkg::OFS_ZONE2_CFG: st_d.rdata = st_q.zone2_pin_config_word;
        bmsd_pkg::OFS_DEBUG_CFG: st_d.rdata = st_q.debug_pin_config_copy;
        bmsd_pkg::OFS_ZONE1_TBL_LO: st_d.rdata = st_q.zone1_table_low_word;
        bmsd_pkg::OFS_ZONE1_TBL_HI: st_d.rdata = st_q.zone1_table_high_word;
        bmsd_pkg::OFS_ZONE2_TBL_LO: st_d.rdata = st_q.zone2_table_low_word;
        bmsd_pkg::OFS_ZONE2_TBL_HI: st_d.rdata = st_q.zone2_table_high_word;
        bmsd_pkg::OFS_DEBUG_TBL_LO: st_d.rdata = st_q.debug_table_low_copy;
        bmsd_pkg::OFS_DEBUG_TBL_HI: st_d.rdata = st_q.debug_table_high_copy;
        bmsd_pkg::OFS_CONTROL: st_d.rdata = {31'h00000000, st_q.use_debug};
        bmsd_pkg::OFS_STATUS: st_d.rdata = status_word;
        bmsd_pkg::OFS_FLASH_ADDR: st_d.rdata = st_q.flash_addr;
        default: st_d.rdata = 32'h00000000;
      endcase
    end

    // pick the config source and its table
    if (st_q.use_debug)
    begin
      cfg_word = st_q.debug_pin_config_copy;
      tbl_word = {st_q.debug_table_high_copy, st_q.debug_table_low_copy};
    end
    else if (st_q.zone2_pin_config_word != bmsd_pkg::OTP_BLANK)
    begin
      cfg_word = st_q.zone2_pin_config_word;
      tbl_word = {st_q.zone2_table_high_word, st_q.zone2_table_low_word};
    end

    // fallback of the latched entry to the final mode
    if (!entry_supported(entry_sel))
    begin
      mode_sel = bmsd_pkg::MODE_WAIT;
    end
    base_sel = {3'h0, mode_sel[bmsd_pkg::MODE_W-1:0]};

    unique case (st_q.state)
      bmsd_pkg::ST_IDLE:
      begin
        st_d.state = bmsd_pkg::ST_RESOLVE;
      end
      bmsd_pkg::ST_RESOLVE:
      begin
        st_d.src = st_q.use_debug ? bmsd_pkg::SRC_DEBUG :
                   (st_q.zone2_pin_config_word != bmsd_pkg::OTP_BLANK) ?
                   bmsd_pkg::SRC_ZONE2 : bmsd_pkg::SRC_ZONE1;
        st_d.key_ok = (cfg_word[bmsd_pkg::KEY_LSB +: 8] == bmsd_pkg::CFG_KEY);
        if (st_d.key_ok)
        begin
          st_d.select_pin_zero = pin_fix(cfg_word[bmsd_pkg::PIN0_LSB +: 8], bmsd_pkg::DEF_PIN0);
          st_d.select_pin_one = pin_fix(cfg_word[bmsd_pkg::PIN1_LSB +: 8], bmsd_pkg::DEF_PIN1);
          st_d.select_pin_two = pin_fix(cfg_word[bmsd_pkg::PIN2_LSB +: 8], bmsd_pkg::DEF_PIN2);
          st_d.table_word = tbl_word;
        end
        else
        begin
          st_d.select_pin_zero = bmsd_pkg::DEF_PIN0;
          st_d.select_pin_one = bmsd_pkg::DEF_PIN1;
          st_d.select_pin_two = bmsd_pkg::DEF_PIN2;
          st_d.table_word = bmsd_pkg::FACTORY_TABLE;
        end
        st_d.state = bmsd_pkg::ST_SAMPLE;
      end
      bmsd_pkg::ST_SAMPLE:
      begin
        // all pins disabled gives index zero; n enabled pins reach 2**n entries
        st_d.index = {pin_level(st_q.select_pin_two, gpio_level),
                      pin_level(st_q.select_pin_one, gpio_level),
                      pin_level(st_q.select_pin_zero, gpio_level)};
        st_d.state = bmsd_pkg::ST_DECODE;
      end
      bmsd_pkg::ST_DECODE:
      begin
        st_d.entry = entry_sel;
        st_d.mode = mode_sel;
        st_d.usb = 1'b0;
        st_d.trap = 1'b0;
        st_d.flash_addr = 32'h00000000;
        st_d.xtal = (base_sel == bmsd_pkg::MODE_CAN) || (base_sel == bmsd_pkg::MODE_MCAN);
        st_d.wdog = (mode_sel != bmsd_pkg::MODE_WAIT_NO_WDOG);
        st_d.ab_wait = (base_sel == bmsd_pkg::MODE_UART) && !st_q.ab_lock;
        if (base_sel == bmsd_pkg::MODE_FLASH || base_sel == bmsd_pkg::MODE_LFU)
        begin
          st_d.flash_addr = flash_addr_of(mode_sel[7:bmsd_pkg::OPT_LSB]);
        end
        // only the default flash option has a blank-address fallback
        if (mode_sel == bmsd_pkg::MODE_FLASH && !flash_entry_programmed)
        begin
          if (usb_present)
          begin
            st_d.usb = 1'b1;
            st_d.mode = bmsd_pkg::MODE_USB;
            st_d.flash_addr = 32'h00000000;
          end
          else
          begin
            st_d.trap = 1'b1;
          end
        end
        st_d.done = 1'b1;
        st_d.state = bmsd_pkg::ST_DONE;
      end
      bmsd_pkg::ST_DONE:
      begin
        // uart boot keeps waiting until an autobaud character arrives
        ab_char = uart_rx_valid && ((uart_rx_data == bmsd_pkg::CHAR_UPPER_A) ||
                                    (uart_rx_data == bmsd_pkg::CHAR_LOWER_A));
        if (st_q.ab_wait && ab_char)
        begin
          st_d.ab_lock = 1'b1;
          st_d.ab_wait = 1'b0;
        end
      end
    endcase
  end

  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      st_q <= '0;
      st_q.zone1_pin_config_word <= bmsd_pkg::OTP_BLANK;
      st_q.zone2_pin_config_word <= bmsd_pkg::OTP_BLANK;
      st_q.debug_pin_config_copy <= bmsd_pkg::OTP_BLANK;
      st_q.zone1_table_low_word <= bmsd_pkg::OTP_BLANK;
      st_q.zone1_table_high_word <= bmsd_pkg::OTP_BLANK;
      st_q.zone2_table_low_word <= bmsd_pkg::OTP_BLANK;
      st_q.zone2_table_high_word <= bmsd_pkg::OTP_BLANK;
      st_q.debug_table_low_copy <= bmsd_pkg::OTP_BLANK;
      st_q.debug_table_high_copy <= bmsd_pkg::OTP_BLANK;
      st_q.state <= bmsd_pkg::ST_IDLE;
      st_q.select_pin_zero <= bmsd_pkg::PIN_DISABLED;
      st_q.select_pin_one <= bmsd_pkg::PIN_DISABLED;
      st_q.select_pin_two <= bmsd_pkg::PIN_DISABLED;
      st_q.wdog <= 1'b1;
      hreadyout <= 1'b0;
    end
    else
    begin
      st_q <= st_d;
      hreadyout <= 1'b1;
    end
  end

  // constant outputs, still taken from flip-flops
  always_ff @(posedge clock)
  begin
    periph_instance <= bmsd_pkg::FIRST_INSTANCE;
    hresp <= 1'b0;
  end

  assign hrdata = st_q.rdata;
  assign boot_done = st_q.done;
  assign boot_index = st_q.index;
  assign boot_entry = st_q.entry;
  assign boot_mode = st_q.mode;
  assign usb_boot = st_q.usb;
  assign illegal_trap = st_q.trap;
  assign xtal_enable = st_q.xtal;
  assign watchdog_enable = st_q.wdog;
  assign autobaud_wait = st_q.ab_wait;
  assign autobaud_locked = st_q.ab_lock;
  assign flash_entry_addr = st_q.flash_addr;

endmodule

// File: verilog/bmsd_pkg.sv
// constants, register map and types for the boot mode select decoder
package bmsd_pkg;

  // register byte offsets on the bus
  localparam logic [7:0] OFS_ZONE1_CFG = 8'h00;
  localparam logic [7:0] OFS_ZONE2_CFG = 8'h04;
  localparam logic [7:0] OFS_DEBUG_CFG = 8'h08;
  localparam logic [7:0] OFS_ZONE1_TBL_LO = 8'h0C;
  localparam logic [7:0] OFS_ZONE1_TBL_HI = 8'h10;
  localparam logic [7:0] OFS_ZONE2_TBL_LO = 8'h14;
  localparam logic [7:0] OFS_ZONE2_TBL_HI = 8'h18;
  localparam logic [7:0] OFS_DEBUG_TBL_LO = 8'h1C;
  localparam logic [7:0] OFS_DEBUG_TBL_HI = 8'h20;
  localparam logic [7:0] OFS_CONTROL = 8'h24;
  localparam logic [7:0] OFS_STATUS = 8'h28;
  localparam logic [7:0] OFS_FLASH_ADDR = 8'h2C;

  // control register bits
  localparam int CTRL_USE_DEBUG_BIT = 0;
  localparam int CTRL_RERUN_BIT = 1;

  // unprogrammed one-time memory reads as all ones
  localparam logic [31:0] OTP_BLANK = 32'hFFFFFFFF;

  // pin configuration word layout
  localparam int KEY_LSB = 24;
  localparam int PIN2_LSB = 16;
  localparam int PIN1_LSB = 8;
  localparam int PIN0_LSB = 0;
  localparam logic [7:0] CFG_KEY = 8'h5A;
  localparam logic [7:0] PIN_DISABLED = 8'hFF;

  // factory default select pins
  localparam logic [7:0] DEF_PIN0 = 8'h20;
  localparam logic [7:0] DEF_PIN1 = 8'h18;
  localparam logic [7:0] DEF_PIN2 = PIN_DISABLED;

  // pins that may never serve as select pins
  localparam logic [7:0] BAD_PIN_A = 8'h14;
  localparam logic [7:0] BAD_PIN_B = 8'h15;
  localparam logic [7:0] BAD_PIN_C = 8'h24;
  localparam logic [7:0] BAD_PIN_D = 8'h26;
  localparam logic [7:0] BAD_RANGE_LO = 8'h3E;
  localparam logic [7:0] BAD_RANGE_HI = 8'hDF;

  // boot table entry values
  localparam logic [7:0] MODE_PARALLEL = 8'h00;
  localparam logic [7:0] MODE_UART = 8'h01;
  localparam logic [7:0] MODE_CAN = 8'h02;
  localparam logic [7:0] MODE_FLASH = 8'h03;
  localparam logic [7:0] MODE_WAIT = 8'h04;
  localparam logic [7:0] MODE_WAIT_NO_WDOG = 8'h24;
  localparam logic [7:0] MODE_RAM = 8'h05;
  localparam logic [7:0] MODE_SPI = 8'h06;
  localparam logic [7:0] MODE_I2C = 8'h07;
  localparam logic [7:0] MODE_MCAN = 8'h08;
  localparam logic [7:0] MODE_USB = 8'h09;
  localparam logic [7:0] MODE_LFU = 8'h0B;
  localparam int MODE_W = 5;
  localparam int OPT_LSB = 5;

  // table used when no valid key is present: pins one and zero pick entries 0..3
  localparam logic [63:0] FACTORY_TABLE = 64'h0303030303020100;

  // flash entry points by option
  localparam logic [31:0] FLASH_ENTRY_0 = 32'h00080000;
  localparam logic [31:0] FLASH_ENTRY_1 = 32'h00088000;
  localparam logic [31:0] FLASH_ENTRY_2 = 32'h000C0000;
  localparam logic [31:0] FLASH_ENTRY_3 = 32'h000C8000;
  localparam logic [31:0] FLASH_ENTRY_4 = 32'h00100000;

  // autobaud characters
  localparam logic [7:0] CHAR_UPPER_A = 8'h41;
  localparam logic [7:0] CHAR_LOWER_A = 8'h61;

  // peripheral instance used by every peripheral boot
  localparam logic [1:0] FIRST_INSTANCE = 2'h0;

  // source of the pin configuration
  localparam logic [1:0] SRC_ZONE1 = 2'h0;
  localparam logic [1:0] SRC_ZONE2 = 2'h1;
  localparam logic [1:0] SRC_DEBUG = 2'h2;

  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_RESOLVE = 5'b00010,
    ST_SAMPLE = 5'b00100,
    ST_DECODE = 5'b01000,
    ST_DONE = 5'b10000
  } bmsd_state_t;

endpackage
